/* sim/frame_feed.sv */
// far-side model: parser and match stages, one frame or stage action per
// request pulse from the bench.
// assumes requests are pulsed for one cycle by nonblocking assignment.
`timescale 1ns/10ps
module frame_feed (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire qos_map_pkg::frame_t frm_i,
  input wire logic act_send_i,
  input wire qos_map_pkg::stage_act_t act_i,
  output qos_map_pkg::frame_t frame_o,
  output qos_map_pkg::stage_act_t act_o
);
  import qos_map_pkg::*;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_o <= '0;
      act_o <= '0;
    end else begin
      // each frame brings one lookup pair per stage match
      // valid is the top bit of both carriers, so one assignment each
      if (send_i) begin
        frame_o <= {1'b1, frm_i[$bits(frame_t)-2:0]};
      end else if (frame_o.valid) begin
        // released fields turn to garbage, never the last frame
        frame_o <= {1'b0, ~frame_o[$bits(frame_t)-2:0]};
      end
      if (act_send_i) begin
        act_o <= {1'b1, act_i[$bits(stage_act_t)-2:0]};
      end else if (act_o.valid) begin
        act_o <= {1'b0, ~act_o[$bits(stage_act_t)-2:0]};
      end
    end
  end
endmodule

/* sim/qos_map_tb.sv */
// self-checking bench for the range, cascade and qos mapping block.
// assumes the far-side model in frame_feed and an axi4-lite master here.
`timescale 1ns/10ps
module qos_map_tb;
  import qos_map_pkg::*;
  logic ref_clk_i;
  logic rst_i;
  logic stage_start;
  logic send;
  logic act_send;
  axil_req_t axi_req;
  axil_rsp_t axi_rsp;
  frame_t f;
  frame_t frm;
  stage_act_t a;
  stage_act_t act;
  logic [IDX_W-1:0] gidx;
  logic [OFF_W-1:0] koff;
  result_t res;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  qos_t cur;
  qos_t e;
  localparam map_key_t CK [11] = '{key_pcp, key_dp_outer, key_dp_middle,
    key_dp_inner, key_dscp_ip, key_dscp_all, key_tc, key_pcp, key_dscp_ip,
    key_dscp_all, key_dp_outer};
  localparam logic [7:0] CB [11] = '{8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32,
    8'h3c, 8'h50, 8'h5a, 8'h64, 8'hfa, 8'hff};
  localparam logic [10:0] CA [11] = '{11'h055, 11'h0ad, 11'h0f2, 11'h14f,
    11'h1bb, 11'h22d, 11'h284, 11'h2d6, 11'h34b, 11'h7fb, 11'h005};
  localparam logic [10:0] CI = 11'h6df;

  qos_map i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .axi_req_i(axi_req),
    .axi_rsp_o(axi_rsp), .stage_start_i(stage_start), .stage_act_i(act),
    .generic_index_o(gidx), .key_offset_o(koff), .frame_i(frm),
    .result_o(res));
  frame_feed i_feed (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .send_i(send),
    .frm_i(f), .act_send_i(act_send), .act_i(a), .frame_o(frm),
    .act_o(act));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge ref_clk_i);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= ad;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    while (1) begin
      @(posedge ref_clk_i);
      if (!aw_d && axi_rsp.awready === 1'b1) begin
        aw_d = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (!w_d && axi_rsp.wready === 1'b1) begin
        w_d = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
      if (axi_rsp.bvalid === 1'b1) break;
    end
    axi_req.bready <= 1'b0;
    chk(32'(axi_rsp.bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] ad);
    logic ar_d;
    ar_d = 1'b0;
    @(posedge ref_clk_i);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= ad;
    axi_req.rready <= 1'b1;
    while (1) begin
      @(posedge ref_clk_i);
      if (!ar_d && axi_rsp.arready === 1'b1) begin
        ar_d = 1'b1;
        axi_req.arvalid <= 1'b0;
      end
      if (axi_rsp.rvalid === 1'b1) break;
    end
    rd = axi_rsp.rdata;
    rr = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  // result is due exactly one cycle after the frame is presented
  task automatic frame_go();
    @(posedge ref_clk_i);
    send <= 1'b1;
    @(posedge ref_clk_i);
    send <= 1'b0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(32'(res.valid), 32'h1);
  endtask

  task automatic act_go();
    @(posedge ref_clk_i);
    act_send <= 1'b1;
    @(posedge ref_clk_i);
    act_send <= 1'b0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic map_set(input logic [10:0] ad, input qos_t q,
                         input logic [6:0] en);
    axi_wr(ADDR_MAP_ADDR, 32'(ad), RESP_OKAY);
    axi_wr(ADDR_MAP_DATA, 32'(q), RESP_OKAY);
    axi_wr(ADDR_SET_CTRL, 32'(en), RESP_OKAY);
  endtask

  function automatic qos_t qv(input int i);
    return qos_t'(21'(i * 21'h0a5a5) ^ 21'h1c3e7);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    axi_req = '0;
    stage_start = 1'b0;
    send = 1'b0;
    act_send = 1'b0;
    f = '0;
    a = '0;
    cur = qos_t'(21'h0abcde);
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    axi_rd(ADDR_RNG_TYPE + 8'h04);
    chk(rd, 32'h0);
    axi_rd(ADDR_RNG_BOUND + 8'h04);
    chk(rd, {BOUND_HI_RST, BOUND_LO_RST});
    axi_wr(8'h80, 32'h1, RESP_SLVERR);
    axi_rd(8'h80);
    chk({rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
    $display("test registers done");

    for (int i = 0; i < 8; i++) begin
      axi_wr(ADDR_RNG_TYPE + 8'(4 * i), 32'(i), RESP_OKAY);
      axi_wr(ADDR_RNG_BOUND + 8'(4 * i), 32'h0020_0010, RESP_OKAY);
    end
    axi_rd(ADDR_RNG_BOUND + 8'h1c);
    chk(rd, 32'h0020_0010);
    f.l4 = 1'b1;
    f.ip = 1'b1;
    f.sport = 16'h0010;
    f.dport = 16'h0021;
    f.vid = 12'h020;
    f.dscp = 6'h0f;
    f.etype = 16'h0020;
    frame_go();
    chk(32'(res.range_flags_key_field), 32'h0);
    f.has_range = 1'b1;
    frame_go();
    chk(32'(res.range_flags_key_field), 32'h5c);
    f.l4 = 1'b0;
    f.ip = 1'b0;
    f.dscp = 6'h10;
    frame_go();
    chk(32'(res.range_flags_key_field), 32'h50);
    f.l4 = 1'b1;
    f.ip = 1'b1;
    f.sport = 16'h000f;
    f.dport = 16'h0020;
    frame_go();
    chk(32'(res.range_flags_key_field), 32'h7a);
    axi_wr(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
    axi_rd(ADDR_STATUS);
    chk(rd & 32'hffff_00ff, 32'h0004_007a);
    $display("test ranges done");

    a = '{1'b1, 1'b1, 12'h005, 1'b1, 8'h02};
    act_go();
    chk({gidx, 12'(koff)}, {12'h005, 12'h002});
    a = '{1'b1, 1'b0, 12'h7ff, 1'b1, 8'h03};
    act_go();
    chk({gidx, 12'(koff)}, {12'h005, 12'h005});
    @(posedge ref_clk_i);
    stage_start <= 1'b1;
    @(posedge ref_clk_i);
    stage_start <= 1'b0;
    @(negedge ref_clk_i);
    chk({gidx, 12'(koff)}, 24'h0);
    $display("test cascade done");

    for (int i = 0; i < 11; i++) begin
      map_set(CA[i], qv(i), 7'h7f);
    end
    axi_wr(ADDR_MAP_ADDR, 32'(CA[0]), RESP_OKAY);
    axi_rd(ADDR_MAP_DATA);
    chk(rd, 32'(qv(0)));
    f.cur = cur;
    f.outer = '{1'b1, 3'h5};
    f.middle = '{1'b0, 3'h2};
    f.inner = '{1'b1, 3'h7};
    f.port_tag = '{1'b0, 3'h6};
    f.dscp = 6'h2b;
    f.tc = 3'h4;
    f.lk1 = '0;
    for (int i = 0; i < 11; i++) begin
      f.lk0 = '{1'b1, CB[i], CK[i]};
      f.ip = CI[i];
      f.tag_cnt = (i == 7) ? 2'h0 : 2'h3;
      e = (i == 8) ? cur : qv(i);
      frame_go();
      chk(32'(res.qos), 32'(e));
    end
    map_set(11'h3c5, qv(20), 7'h04);
    map_set(11'h415, qv(21), 7'h24);
    f.tag_cnt = 2'h3;
    f.lk0 = '{1'b1, 8'h78, key_pcp};
    f.lk1 = '{1'b1, 8'h82, key_pcp};
    e = cur;
    e.pcp = qv(21).pcp;
    e.dscp = qv(21).dscp;
    frame_go();
    chk(32'(res.qos), 32'(e));
    f.lk1 = '0;
    e = cur;
    e.pcp = qv(20).pcp;
    frame_go();
    chk(32'(res.qos), 32'(e));
    $display("test mapping done");
    end_sim();
  end
endmodule

/* src/qos_map.sv */
// range checkers, lookup cascade state and shared qos mapping table.
// assumes an axi4-lite master and a parser that presents one frame per
// valid pulse; results come one cycle later.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

module qos_map (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire qos_map_pkg::axil_req_t axi_req_i,
  output qos_map_pkg::axil_rsp_t axi_rsp_o,
  input wire logic stage_start_i,
  input wire qos_map_pkg::stage_act_t stage_act_i,
  output logic [qos_map_pkg::IDX_W-1:0] generic_index_o,
  output logic [qos_map_pkg::OFF_W-1:0] key_offset_o,
  input wire qos_map_pkg::frame_t frame_i,
  output qos_map_pkg::result_t result_o
);
  import qos_map_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [RNG_N-1:0][2:0] rng_type;
    logic [RNG_N-1:0][15:0] rng_lo;
    logic [RNG_N-1:0][15:0] rng_hi;
    logic [10:0] map_addr;
    logic [IDX_W-1:0] gidx;
    logic [OFF_W-1:0] koff;
    logic [15:0] frame_cnt;
    result_t res;
  } state_t;

  typedef struct packed {
    logic hit;
    logic [ROW_W-1:0] row;
    logic [ENT_W-1:0] ent;
  } map_pos_t;

  state_t q, d;
  qos_t map_tbl [MAP_ENTRIES];
  logic [SET_W-1:0] set_tbl [MAP_ROWS];
  logic map_we, set_we;
  logic [31:0] wr_val;

  ////////////////////////////////////////////////////////////////////
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic rng_match(input logic [2:0] t, input frame_t f,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    logic m;
    m = 1'b0;
    case (rng_type_t'(t))
      rng_dport: m = f.l4 && in_range(f.dport, lo, hi);
      rng_sport: m = f.l4 && in_range(f.sport, lo, hi);
      rng_sdport: m = f.l4 && (in_range(f.sport, lo, hi) ||
                               in_range(f.dport, lo, hi));
      rng_vid: m = in_range({4'h0, f.vid}, lo, hi);
      rng_dscp: m = f.ip && in_range({10'h000, f.dscp}, lo, hi);
      rng_etype: m = in_range(f.etype, lo, hi);
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // v = 8*dei + pcp spans two rows
  function automatic map_pos_t tag_pos(input tag_t t,
                                       input logic [ROW_W-1:0] base,
                                       input logic [ROW_W-1:0] extra);
    map_pos_t p;
    p.hit = 1'b1;
    p.row = base + extra + {7'h00, t.dei};
    p.ent = t.pcp;
    return p;
  endfunction

  function automatic map_pos_t map_pos(input lookup_t lk, input frame_t f);
    map_pos_t p;
    tag_t sel;
    logic untagged;
    p = '0;
    untagged = (f.tag_cnt == 2'h0);
    sel = untagged ? f.port_tag : f.outer;
    case (lk.key)
      key_pcp: begin
        p.hit = 1'b1;
        p.row = lk.map_row_base;
        p.ent = sel.pcp;
      end
      key_dp_outer: p = tag_pos(sel, lk.map_row_base, 8'h00);
      key_dp_middle:
        p = tag_pos(untagged ? f.port_tag : f.middle, lk.map_row_base, 8'h00);
      key_dp_inner:
        p = tag_pos(untagged ? f.port_tag : f.inner, lk.map_row_base, 8'h00);
      key_dscp_ip, key_dscp_all: begin
        if (f.ip) begin
          p.hit = 1'b1;
          p.row = lk.map_row_base + {5'h00, f.dscp[5:3]};
          p.ent = f.dscp[2:0];
        end else if (lk.key == key_dscp_all) begin
          p = tag_pos(sel, lk.map_row_base, 8'h08);
        end
      end
      key_tc: begin
        p.hit = 1'b1;
        p.row = lk.map_row_base;
        p.ent = f.tc;
      end
      default: p = '0;
    endcase
    p.hit = p.hit && lk.en;
    return p;
  endfunction

  // the later lookup is applied last so its enabled fields win
  function automatic qos_t apply_map(input qos_t cur, input qos_t e,
                                     input logic [SET_W-1:0] en);
    qos_t r;
    r = cur;
    if (en[EN_COS]) r.class_of_service_id = e.class_of_service_id;
    if (en[EN_DEI]) r.dei = e.dei;
    if (en[EN_PCP]) r.pcp = e.pcp;
    if (en[EN_QCL]) r.qclass = e.qclass;
    if (en[EN_DP]) r.dp = e.dp;
    if (en[EN_DSCP]) r.dscp = e.dscp;
    if (en[EN_TC]) r.tc = e.tc;
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // register read value by address, zero and error for unmapped
  function automatic logic [32:0] rd_word(input state_t s, input qos_t me,
                                          input logic [SET_W-1:0] se,
                                          input logic [7:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    if (a[7:5] == ADDR_RNG_TYPE[7:5]) begin
      r[2:0] = s.rng_type[a[4:2]];
    end else if (a[7:5] == ADDR_RNG_BOUND[7:5]) begin
      r[BOUND_LO_LSB +: 16] = s.rng_lo[a[4:2]];
      r[BOUND_HI_LSB +: 16] = s.rng_hi[a[4:2]];
    end else if (a == ADDR_MAP_ADDR) begin
      r[10:0] = s.map_addr;
    end else if (a == ADDR_MAP_DATA) begin
      r[$bits(qos_t)-1:0] = me;
    end else if (a == ADDR_SET_CTRL) begin
      r[SET_W-1:0] = se;
    end else if (a == ADDR_STATUS) begin
      r[RNG_N-1:0] = s.res.range_flags_key_field;
      r[STAT_CNT_LSB +: 16] = s.frame_cnt;
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction

  logic [32:0] rd_q;
  logic [32:0] wr_chk;
  map_pos_t pos0, pos1;
  qos_t mid, fin;

  always_comb begin
    d = q;
    map_we = 1'b0;
    set_we = 1'b0;
    wr_val = 32'h0000_0000;
    pos0 = map_pos(frame_i.lk0, frame_i);
    pos1 = map_pos(frame_i.lk1, frame_i);
    mid = frame_i.cur;
    if (pos0.hit) begin
      mid = apply_map(mid, map_tbl[{pos0.row, pos0.ent}],
                      set_tbl[pos0.row]);
    end
    fin = mid;
    if (pos1.hit) begin
      fin = apply_map(mid, map_tbl[{pos1.row, pos1.ent}],
                      set_tbl[pos1.row]);
    end
    rd_q = rd_word(q, map_tbl[q.map_addr], set_tbl[q.map_addr[10:3]],
                   axi_req_i.araddr);
    wr_chk = rd_word(q, map_tbl[q.map_addr], set_tbl[q.map_addr[10:3]],
                     q.aw_addr);

    // write channel: address and data may arrive in either order
    if (axi_req_i.awvalid && !q.aw_have) begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && !q.w_have) begin
      d.w_have = 1'b1;
      d.w_data = axi_req_i.wdata;
      d.w_strb = axi_req_i.wstrb;
    end
    if (q.bvalid && axi_req_i.bready) d.bvalid = 1'b0;
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_chk[32] ? RESP_SLVERR : RESP_OKAY;
      wr_val = merge(wr_chk[31:0], q.w_data, q.w_strb);
      if (q.aw_addr[7:5] == ADDR_RNG_TYPE[7:5]) begin
        d.rng_type[q.aw_addr[4:2]] = wr_val[2:0];
      end else if (q.aw_addr[7:5] == ADDR_RNG_BOUND[7:5]) begin
        d.rng_lo[q.aw_addr[4:2]] = wr_val[BOUND_LO_LSB +: 16];
        d.rng_hi[q.aw_addr[4:2]] = wr_val[BOUND_HI_LSB +: 16];
      end else if (q.aw_addr == ADDR_MAP_ADDR) begin
        d.map_addr = wr_val[10:0];
      end else if (q.aw_addr == ADDR_MAP_DATA) begin
        map_we = 1'b1;
      end else if (q.aw_addr == ADDR_SET_CTRL) begin
        set_we = 1'b1;
      end
    end

    // read channel: one read in flight, answered the next cycle
    if (q.rvalid && axi_req_i.rready) d.rvalid = 1'b0;
    if (axi_req_i.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = rd_q[31:0];
      d.rresp = rd_q[32] ? RESP_SLVERR : RESP_OKAY;
    end

    // cascade: generic index and key offset carried between stages
    if (stage_start_i) begin
      d.gidx = '0;
      d.koff = '0;
    end else if (stage_act_i.valid) begin
      if (stage_act_i.next_index_control) begin
        d.gidx = stage_act_i.next_index_value;
      end
      if (stage_act_i.layer_step) begin
        d.koff = q.koff + stage_act_i.layer_w16;
      end
    end

    // frame result, flags held for status readback
    d.res.valid = frame_i.valid;
    if (frame_i.valid) begin
      d.frame_cnt = q.frame_cnt + 16'h0001;
      d.res.qos = fin;
      for (int i = 0; i < RNG_N; i++) begin
        d.res.range_flags_key_field[i] = frame_i.has_range &&
          rng_match(q.rng_type[i], frame_i, q.rng_lo[i],
                    q.rng_hi[i]);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      for (int i = 0; i < RNG_N; i++) begin
        q.rng_lo[i] <= BOUND_LO_RST;
        q.rng_hi[i] <= BOUND_HI_RST;
      end
    end else begin
      q <= d;
    end
  end

  // table contents are undefined until software loads them
  always_ff @(posedge ref_clk_i) begin
    if (map_we) map_tbl[q.map_addr] <= qos_t'(wr_val[$bits(qos_t)-1:0]);
    if (set_we) set_tbl[q.map_addr[10:3]] <= wr_val[SET_W-1:0];
  end

  always_comb begin
    axi_rsp_o.awready = !q.aw_have;
    axi_rsp_o.wready = !q.w_have;
    axi_rsp_o.bvalid = q.bvalid;
    axi_rsp_o.bresp = q.bresp;
    axi_rsp_o.arready = !q.rvalid;
    axi_rsp_o.rvalid = q.rvalid;
    axi_rsp_o.rdata = q.rdata;
    axi_rsp_o.rresp = q.rresp;
  end

  assign generic_index_o = q.gidx;
  assign key_offset_o = q.koff;
  assign result_o = q.res;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  no_range_key_a: assert property (frame_i.valid &&
    !frame_i.has_range |=> result_o.range_flags_key_field == '0)
    else $error("flags set without range key");
  result_next_a: assert property (frame_i.valid |=> result_o.valid)
    else $error("result missing one cycle after frame");
  dport_l4_a: assert property (frame_i.valid && !frame_i.l4 &&
    q.rng_type[1] == 3'(rng_dport) |=> !result_o.range_flags_key_field[1])
    else $error("port checker matched non l4 frame");
  dscp_ip_a: assert property (frame_i.valid && !frame_i.ip &&
    q.rng_type[5] == 3'(rng_dscp) |=> !result_o.range_flags_key_field[5])
    else $error("dscp checker matched non ip frame");
  bound_incl_a: assert property (frame_i.valid &&
    frame_i.has_range && q.rng_type[6] == 3'(rng_etype) &&
    q.rng_lo[6] <= q.rng_hi[6] &&
    (frame_i.etype == q.rng_lo[6] || frame_i.etype == q.rng_hi[6])
    |=> result_o.range_flags_key_field[6])
    else $error("range bound not inclusive");
  idx_load_a: assert property (stage_act_i.valid &&
    !stage_start_i && stage_act_i.next_index_control
    |=> generic_index_o == $past(stage_act_i.next_index_value))
    else $error("generic index not loaded");
  off_reset_a: assert property (stage_start_i
    |=> key_offset_o == '0)
    else $error("key offset not cleared at start");
  no_map_a: assert property (frame_i.valid && !frame_i.lk0.en &&
    !frame_i.lk1.en |=> result_o.qos == $past(frame_i.cur))
    else $error("qos changed with no lookup");
  bresp_hold_a: assert property (axi_rsp_o.bvalid && !axi_req_i.bready
    |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (axi_req_i.arvalid && axi_rsp_o.arready
    |=> axi_rsp_o.rvalid)
    else $error("read not answered next cycle");

  wr_done_c: cover property (axi_rsp_o.bvalid && axi_req_i.bready);
  flag_hit_c: cover property (result_o.valid &&
    result_o.range_flags_key_field != '0);
  two_maps_c: cover property (frame_i.valid && pos0.hit && pos1.hit);
  cascade_c: cover property (stage_act_i.valid && stage_act_i.layer_step);

endmodule

/* src/qos_map_pkg.sv */
// constants, field layouts and carrier types of the range checker,
// cascade and qos mapping block.
// assumes one core clock; all frame inputs are synchronous to it.
package qos_map_pkg;

  localparam int RNG_N = 8;
  localparam int MAP_ROWS = 256;
  localparam int MAP_ENTRIES = 2048;
  localparam int ROW_W = 8;
  localparam int ENT_W = 3;
  localparam int IDX_W = 12;
  localparam int OFF_W = 8;
  localparam int SET_W = 7;

  // register byte addresses
  localparam logic [7:0] ADDR_RNG_TYPE = 8'h00;
  localparam logic [7:0] ADDR_RNG_BOUND = 8'h20;
  localparam logic [7:0] ADDR_MAP_ADDR = 8'h40;
  localparam logic [7:0] ADDR_MAP_DATA = 8'h44;
  localparam logic [7:0] ADDR_SET_CTRL = 8'h48;
  localparam logic [7:0] ADDR_STATUS = 8'h4c;

  localparam int BOUND_LO_LSB = 0;
  localparam int BOUND_HI_LSB = 16;
  localparam int STAT_CNT_LSB = 16;

  localparam logic [15:0] BOUND_LO_RST = 16'h0000;
  localparam logic [15:0] BOUND_HI_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // set control enable bit positions
  localparam int EN_COS = 0;
  localparam int EN_DEI = 1;
  localparam int EN_PCP = 2;
  localparam int EN_QCL = 3;
  localparam int EN_DP = 4;
  localparam int EN_DSCP = 5;
  localparam int EN_TC = 6;

  typedef enum logic [2:0] {
    rng_off, rng_dport, rng_sport, rng_sdport, rng_vid, rng_dscp, rng_etype
  } rng_type_t;

  typedef enum logic [2:0] {
    key_none, key_pcp, key_dp_outer, key_dp_middle, key_dp_inner,
    key_dscp_ip, key_dscp_all, key_tc
  } map_key_t;

  typedef struct packed {logic dei; logic [2:0] pcp;} tag_t;

  typedef struct packed {
    logic [2:0] class_of_service_id;
    logic dei;
    logic [2:0] pcp;
    logic [2:0] qclass;
    logic [1:0] dp;
    logic [5:0] dscp;
    logic [2:0] tc;
  } qos_t;

  typedef struct packed {
    logic en;
    logic [ROW_W-1:0] map_row_base;
    map_key_t key;
  } lookup_t;

  typedef struct packed {
    logic valid;
    logic has_range;
    logic l4;
    logic ip;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [11:0] vid;
    logic [5:0] dscp;
    logic [15:0] etype;
    logic [1:0] tag_cnt;
    tag_t outer;
    tag_t middle;
    tag_t inner;
    tag_t port_tag;
    logic [2:0] tc;
    qos_t cur;
    lookup_t lk1;
    lookup_t lk0;
  } frame_t;

  typedef struct packed {
    logic valid;
    logic next_index_control;
    logic [IDX_W-1:0] next_index_value;
    logic layer_step;
    logic [OFF_W-1:0] layer_w16;
  } stage_act_t;

  typedef struct packed {
    logic valid;
    logic [RNG_N-1:0] range_flags_key_field;
    qos_t qos;
  } result_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage
